// File: core/iob_regs.svh
// Register offsets, field positions, reset values and timing counts of the oscillator block
`ifndef IOB_REGS_SVH
`define IOB_REGS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define IOB_OFS_TUNING      8'h00
`define IOB_OFS_CONTROL     8'h04
`define IOB_OFS_CONFIG      8'h08
`define IOB_OFS_STATUS      8'h0c

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define IOB_TUN_SRC_BIT     7
`define IOB_TUN_PLL_BIT     6
`define IOB_TUN_TRIM_MSB    4
`define IOB_TUN_RESET       8'h00
`define IOB_CTL_IFS_LSB     4
`define IOB_CTL_IFS_MSB     6
`define IOB_IFS_RESET       3'h4
`define IOB_CFG_RESET       4'h9
`define IOB_CFG_INT_CLKOUT  4'h9
`define IOB_CFG_INT_DUALIO  4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IOB_CLK_MHZ         250
`define IOB_SETTLE_US       1000
`define IOB_SETTLE_CYC      (`IOB_SETTLE_US * `IOB_CLK_MHZ)

`endif

// File: core/iob_pkg.sv
// Types shared by the oscillator block
package iob_pkg;
	// Source that drives the block output
	typedef enum logic [2:0] {
		IOB_SRC_FAST,
		IOB_SRC_POST,
		IOB_SRC_DIV256,
		IOB_SRC_SLOW_RC,
		IOB_SRC_PLL
	} iob_src_t;
	// Trim settling tracker
	typedef enum logic [0:0] {
		IOB_TRIM_STABLE,
		IOB_TRIM_SHIFTING
	} iob_trim_t;
endpackage

// File: core/iob_clkdiv.sv
// Free-running divider: counts fast oscillator ticks and gives divided levels at each power of two
`timescale 1ns/100ps
`default_nettype none
module iob_clkdiv
	import iob_pkg::*;
#(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input  wire logic             CLK,
	input  wire logic             SRST,
	// Source tick and enable
	input  wire logic             TICK,
	input  wire logic             RUN,
	// Divided level outputs, bit k is source divided by 2^(k+1)
	output logic [WIDTH-1:0]      DIV
);
	// Elaboration-time guard on the counter width
	if (WIDTH < 2 || WIDTH > 16) begin : gen_width_bad
		$error("iob_clkdiv: WIDTH out of range");
	end

	logic [WIDTH-1:0] cnt_q;  // Synchronous binary count of source ticks

	// ----------------------------------------------------------------
	// Counter
	// ----------------------------------------------------------------
	// Counter cleared to zero while the source is off, so it draws no toggling
	always_ff @(posedge CLK) begin
		if (SRST || !RUN) begin
			cnt_q <= '0;
		end else if (TICK) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

	assign DIV = cnt_q;
endmodule
`default_nettype wire

// File: core/iob_core.sv
// Internal oscillator control block with AHB-Lite register slave
// Functional notes
// - Fast oscillator feeds clock and postscaler
// - Fast oscillator on for 125 kHz..8 MHz
// - At 31 kHz, source bit gates fast oscillator
// - Slow RC runs when selected or features need
// - Clock-out mode: pin out gives clock/4
// - Dual-I/O mode: both pins are port I/O
// - Five-bit trim field is signed
// - Trim settles within 1 ms, no flag (block flags it on TRIM_SHIFTING and status bit 3)
// - Tuning writes never affect slow RC
// - Source bit picks fast/256 or slow RC
// - PLL multiplies 4 or 8 MHz by four
// - PLL only in internal modes, select 111/110
// - PLL unavailable: bit held zero, writes ignored
// - Unavailable PLL bit reads zero
// - Select maps 111..001 halving, 000 slow
// - Reset selects 1 MHz output
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "iob_regs.svh"
module iob_core
	import iob_pkg::*;
#(
	parameter int SETTLE_CYC = `IOB_SETTLE_CYC,
	parameter int POST_W     = 8
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        SRST,
	// AHB-Lite slave
	input  wire logic        HSEL,
	input  wire logic [7:0]  HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic [31:0]      HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	// Oscillator ticks (one-cycle strobes at each source edge)
	input  wire logic        FAST_OSC_TICK,
	input  wire logic        SLOW_RC_TICK,
	input  wire logic        PLL_TICK,
	input  wire logic        SYS_CLK_TICK,
	// Feature requests for the slow RC
	input  wire logic        PWRUP_TIMER_EN,
	input  wire logic        FAILSAFE_MON_EN,
	input  wire logic        WATCHDOG_EN,
	input  wire logic        TWO_SPEED_EN,
	input  wire logic        SLOW_RC_IS_SYSCLK,
	// Oscillator controls
	output logic             FAST_OSC_EN,
	output logic             SLOW_RC_EN,
	output logic             PLL_EN,
	output logic signed [4:0] FAST_OSC_TRIM,
	output logic             TRIM_SHIFTING,
	output logic             BLOCK_CLK,
	output logic [2:0]       BLOCK_SRC,
	// Pin reuse: osc_pin_in / osc_pin_out
	input  wire logic        PORT_A7_OUT,
	input  wire logic        PORT_A7_OE,
	input  wire logic        PORT_A6_OUT,
	input  wire logic        PORT_A6_OE,
	input  wire logic        OSC_PIN_IN_I,
	input  wire logic        OSC_PIN_OUT_I,
	output logic             OSC_PIN_IN_O,
	output logic             OSC_PIN_IN_OE,
	output logic             OSC_PIN_OUT_O,
	output logic             OSC_PIN_OUT_OE,
	output logic             PORT_A7_IN,
	output logic             PORT_A6_IN
);
	// Elaboration-time guards on the parameters
	if (POST_W != 8) begin : gen_post_w_bad
		$error("iob_core: POST_W must be 8 for the divide-by-256 path");
	end
	if (SETTLE_CYC < 1) begin : gen_settle_bad
		$error("iob_core: SETTLE_CYC must be positive");
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	localparam logic [7:0] TUN_RST = `IOB_TUN_RESET;  // Tuning register reset image
	logic        src_sel_q;     // low_freq_source_sel
	logic        pll_en_q;      // pll_multiplier_en
	logic [4:0]  trim_q;        // freq_trim
	logic [2:0]  ifs_q;         // internal_freq_select
	logic [3:0]  cfg_q;         // osc_config_field
	logic        wr_pend_q;     // Data phase of a write pending
	logic [7:0]  addr_q;        // Latched address phase
	logic        rd_pend_q;     // Data phase of a read pending
	logic [31:0] settle_q;      // Trim settling countdown
	iob_trim_t   trim_st_q;     // Trim settling state
	logic        cko_q;         // Clock/4 output flop
	logic [1:0]  cko_cnt_q;     // Clock/4 divider
	logic        blk_clk_q;     // Output clock flop
	logic [POST_W-1:0] div;     // Postscaler taps
	logic        pll_ok;        // PLL availability
	logic        fast_on;       // Fast oscillator enable
	logic        take;          // Address phase accepted
	iob_src_t    src;           // Selected output source

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	// Zero-wait slave; always OKAY, so unmapped addresses just read zero
	// Limitation: a read whose address phase overlaps the data phase of a
	// write to the same register returns the value from before that write
	assign HREADYOUT = 1'b1;
	assign HRESP     = 1'b0;
	assign take      = HSEL && HREADY && HTRANS[1];

	// Capture the address phase
	always_ff @(posedge CLK) begin
		if (SRST) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else begin
			wr_pend_q <= take && HWRITE;
			rd_pend_q <= take && !HWRITE;
			if (take) begin
				addr_q <= HADDR;
			end
		end
	end

	// PLL only in internal-oscillator configurations at 4 or 8 MHz
	assign pll_ok = (cfg_q == `IOB_CFG_INT_CLKOUT || cfg_q == `IOB_CFG_INT_DUALIO)
	             && (ifs_q[2:1] == 2'b11);

	// Tuning register
	always_ff @(posedge CLK) begin
		if (SRST) begin
			src_sel_q <= TUN_RST[`IOB_TUN_SRC_BIT];
			pll_en_q  <= TUN_RST[`IOB_TUN_PLL_BIT];
			trim_q    <= TUN_RST[`IOB_TUN_TRIM_MSB:0];
		end else begin
			if (wr_pend_q && addr_q == `IOB_OFS_TUNING) begin
				src_sel_q <= HWDATA[`IOB_TUN_SRC_BIT];
				pll_en_q  <= HWDATA[`IOB_TUN_PLL_BIT] && pll_ok;
				trim_q    <= HWDATA[`IOB_TUN_TRIM_MSB:0];
			end else if (!pll_ok) begin
				pll_en_q  <= 1'b0;
			end
		end
	end

	// Control and configuration registers
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ifs_q <= `IOB_IFS_RESET;
			cfg_q <= `IOB_CFG_RESET;
		end else if (wr_pend_q) begin
			if (addr_q == `IOB_OFS_CONTROL) begin
				ifs_q <= HWDATA[`IOB_CTL_IFS_MSB:`IOB_CTL_IFS_LSB];
			end else if (addr_q == `IOB_OFS_CONFIG) begin
				cfg_q <= HWDATA[3:0];
			end
		end
	end

	// Read data flop
	always_ff @(posedge CLK) begin
		if (SRST) begin
			HRDATA <= 32'h0000_0000;
		end else if (take && !HWRITE) begin
			if (HADDR == `IOB_OFS_TUNING) begin
				// Bit 5 reads zero; PLL bit reads zero when unavailable
				HRDATA <= {24'h000000, src_sel_q, pll_en_q && pll_ok, 1'b0, trim_q};
			end else if (HADDR == `IOB_OFS_CONTROL) begin
				HRDATA <= {25'h0000000, ifs_q, 4'h0};
			end else if (HADDR == `IOB_OFS_CONFIG) begin
				HRDATA <= {28'h0000000, cfg_q};
			end else if (HADDR == `IOB_OFS_STATUS) begin
				HRDATA <= {25'h0000000, src, trim_st_q == IOB_TRIM_SHIFTING, PLL_EN, SLOW_RC_EN, FAST_OSC_EN};
			end else begin
				HRDATA <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Trim and settling
	// ----------------------------------------------------------------
	// Trim is passed as signed: 0x0f fastest, 0x10 slowest
	assign FAST_OSC_TRIM = $signed(trim_q);

	// Settle window after each tuning write; software is never stalled
	// A second write inside the window restarts it from the full count
	always_ff @(posedge CLK) begin
		if (SRST) begin
			trim_st_q <= IOB_TRIM_STABLE;
			settle_q  <= 32'h0000_0000;
		end else begin
			case (trim_st_q)
				IOB_TRIM_STABLE: begin
					if (wr_pend_q && addr_q == `IOB_OFS_TUNING) begin
						trim_st_q <= IOB_TRIM_SHIFTING;
						settle_q  <= 32'(SETTLE_CYC - 1);
					end
				end
				IOB_TRIM_SHIFTING: begin
					if (wr_pend_q && addr_q == `IOB_OFS_TUNING) begin
						settle_q <= 32'(SETTLE_CYC - 1);
					end else if (settle_q == 32'h0000_0000) begin
						trim_st_q <= IOB_TRIM_STABLE;
					end else begin
						settle_q <= settle_q - 32'h0000_0001;
					end
				end
				default: trim_st_q <= IOB_TRIM_STABLE;
			endcase
		end
	end
	assign TRIM_SHIFTING = (trim_st_q == IOB_TRIM_SHIFTING);

	// ----------------------------------------------------------------
	// Oscillator enables and source selection
	// ----------------------------------------------------------------
	// Fast oscillator on for nonzero select, or at 31 kHz with source bit set
	assign fast_on     = (ifs_q != 3'h0) || src_sel_q;
	assign FAST_OSC_EN = fast_on;
	// Slow RC ignores the tuning register entirely
	assign SLOW_RC_EN  = SLOW_RC_IS_SYSCLK || PWRUP_TIMER_EN || FAILSAFE_MON_EN
	                  || WATCHDOG_EN || TWO_SPEED_EN;
	assign PLL_EN      = pll_en_q && pll_ok;

	// Output source from select, source bit and PLL
	always_comb begin
		if (PLL_EN) begin
			src = IOB_SRC_PLL;
		end else if (ifs_q == 3'h7) begin
			src = IOB_SRC_FAST;
		end else if (ifs_q != 3'h0) begin
			src = IOB_SRC_POST;
		end else if (src_sel_q) begin
			src = IOB_SRC_DIV256;
		end else begin
			src = IOB_SRC_SLOW_RC;
		end
	end
	assign BLOCK_SRC = src;

	// Postscaler taps of the fast oscillator
	iob_clkdiv #(
		.WIDTH (POST_W)
	) u_post (
		.CLK  (CLK),
		.SRST (SRST),
		.TICK (FAST_OSC_TICK),
		.RUN  (fast_on),
		.DIV  (div)
	);

	// Output clock level; postscaler tap 6-ifs gives 4 MHz..125 kHz
	// Direct sources follow their tick: toggling on it would halve the rate
	always_ff @(posedge CLK) begin
		if (SRST) begin
			blk_clk_q <= 1'b0;
		end else begin
			case (src)
				IOB_SRC_PLL:     blk_clk_q <= PLL_TICK;
				IOB_SRC_FAST:    blk_clk_q <= FAST_OSC_TICK;
				IOB_SRC_POST:    blk_clk_q <= div[3'h6 - ifs_q];
				IOB_SRC_DIV256:  blk_clk_q <= div[POST_W-1];
				default:         blk_clk_q <= SLOW_RC_TICK;
			endcase
		end
	end
	assign BLOCK_CLK = blk_clk_q;

	// ----------------------------------------------------------------
	// Pin reuse
	// ----------------------------------------------------------------
	// System clock divided by four for the clock-out mode
	always_ff @(posedge CLK) begin
		if (SRST) begin
			cko_cnt_q <= 2'h0;
			cko_q     <= 1'b0;
		end else if (SYS_CLK_TICK) begin
			cko_cnt_q <= cko_cnt_q + 2'h1;
			if (cko_cnt_q[0]) begin
				cko_q <= ~cko_q;
			end
		end
	end

	// Pin in is always port A bit 7; pin out is clock/4 or port A bit 6
	assign OSC_PIN_IN_O   = PORT_A7_OUT;
	assign OSC_PIN_IN_OE  = PORT_A7_OE;
	assign PORT_A7_IN     = OSC_PIN_IN_I;
	assign OSC_PIN_OUT_O  = (cfg_q == `IOB_CFG_INT_CLKOUT) ? cko_q : PORT_A6_OUT;
	assign OSC_PIN_OUT_OE = (cfg_q == `IOB_CFG_INT_CLKOUT) ? 1'b1 : PORT_A6_OE;
	assign PORT_A6_IN     = (cfg_q == `IOB_CFG_INT_DUALIO) ? OSC_PIN_OUT_I : 1'b0;
endmodule
`default_nettype wire

// File: verif/iob_core_sva.sv
// Port-level checker of the oscillator block
`timescale 1ns/100ps
`default_nettype none
`include "iob_regs.svh"
module iob_core_chk
	import iob_pkg::*;
#(
	parameter int SETTLE_CYC = 20
) (
	// Clock and reset
	input wire logic                CLK,
	input wire logic                SRST,
	// Bus
	input wire logic                HSEL,
	input wire logic [7:0]          HADDR,
	input wire logic [1:0]          HTRANS,
	input wire logic                HWRITE,
	input wire logic                HREADY,
	input wire logic [31:0]         HRDATA,
	input wire logic                HREADYOUT,
	input wire logic                HRESP,
	// Oscillator controls
	input wire logic                FAST_OSC_EN,
	input wire logic                PLL_EN,
	input wire logic signed [4:0]   FAST_OSC_TRIM,
	input wire logic                TRIM_SHIFTING,
	input wire logic [2:0]          BLOCK_SRC
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SRST);
	logic        go;          // Transfer taken this edge
	logic        wr_tun;      // Tuning write taken
	logic [31:0] shift_cnt_q; // Settling cycles since the last tuning write
	assign go = HSEL && HREADY && HTRANS[1];
	assign wr_tun = go && HWRITE && (HADDR == `IOB_OFS_TUNING);
	// Counter restarts on each tuning write, since a write restarts settling
	always_ff @(posedge CLK) begin
		if (SRST || wr_tun)
			shift_cnt_q <= '0;
		else if (TRIM_SHIFTING)
			shift_cnt_q <= shift_cnt_q + 32'h1;
	end
	sequence tun_write;
		wr_tun ##1 1'b1;
	endsequence
	chk_okay_resp: assert property (HREADYOUT && !HRESP) else $error("bus answer not ready or not okay");
	chk_rdata_hold: assert property (!$past(go && !HWRITE) |-> $stable(HRDATA)) else $error("read data moved");
	chk_src_fast_on: assert property (BLOCK_SRC inside {IOB_SRC_FAST, IOB_SRC_POST, IOB_SRC_DIV256}
		|-> FAST_OSC_EN) else $error("fast source used while disabled");
	chk_rc_fast_off: assert property (BLOCK_SRC == IOB_SRC_SLOW_RC |-> !FAST_OSC_EN)
		else $error("fast oscillator left on");
	chk_pll_needs_fast: assert property (PLL_EN |-> FAST_OSC_EN) else $error("pll without fast source");
	chk_pll_src: assert property (BLOCK_SRC == IOB_SRC_PLL |-> PLL_EN) else $error("pll source while off");
	chk_trim_cause: assert property ($changed(FAST_OSC_TRIM) |-> $past(wr_tun, 2))
		else $error("trim moved without write");
	chk_settle_start: assert property (tun_write |-> ##[0:2] TRIM_SHIFTING) else $error("settling not started");
	chk_settle_hold: assert property ($rose(TRIM_SHIFTING) |-> TRIM_SHIFTING[*8]) else $error("settling cut short");
	chk_settle_bound: assert property (shift_cnt_q <= SETTLE_CYC + 3) else $error("settling too long");
endmodule
`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench of the oscillator block
`timescale 1ns/100ps
`default_nettype none
`include "iob_regs.svh"
module testbench;
	import iob_pkg::*;
	localparam int SETTLE = 20; // Short settle window keeps the run brief
	// Design inputs
	logic CLK, SRST, HSEL, HWRITE, FAST_OSC_TICK, SLOW_RC_TICK, PLL_TICK, SYS_CLK_TICK;
	logic PWRUP_TIMER_EN, FAILSAFE_MON_EN, WATCHDOG_EN, TWO_SPEED_EN, SLOW_RC_IS_SYSCLK;
	logic PORT_A7_OUT, PORT_A7_OE, PORT_A6_OUT, PORT_A6_OE, OSC_PIN_IN_I, OSC_PIN_OUT_I;
	logic [7:0]  HADDR;
	logic [1:0]  HTRANS;
	logic [2:0]  HSIZE;
	logic [31:0] HWDATA, rd;
	// Design outputs
	wire logic [31:0] HRDATA;
	wire logic HREADYOUT, HRESP, FAST_OSC_EN, SLOW_RC_EN, PLL_EN, TRIM_SHIFTING, BLOCK_CLK;
	wire logic signed [4:0] FAST_OSC_TRIM;
	wire logic [2:0] BLOCK_SRC;
	wire logic OSC_PIN_IN_O, OSC_PIN_IN_OE, OSC_PIN_OUT_O, OSC_PIN_OUT_OE, PORT_A7_IN, PORT_A6_IN;
	wire logic HREADY = HREADYOUT; // Single slave: its ready is the bus ready
	int err_total, checked, cyc, n, c, s;
	logic [3:0] cfgs [3] = '{4'h9, 4'h8, 4'h0};
	logic [2:0] sels [3] = '{3'h7, 3'h6, 3'h5};
	logic [4:0] trims [3] = '{5'h0f, 5'h10, 5'h00};
	iob_core #(.SETTLE_CYC(SETTLE), .POST_W(8)) iob_core_inst (.CLK, .SRST, .HSEL, .HADDR, .HTRANS, .HWRITE,
		.HSIZE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .FAST_OSC_TICK, .SLOW_RC_TICK, .PLL_TICK,
		.SYS_CLK_TICK, .PWRUP_TIMER_EN, .FAILSAFE_MON_EN, .WATCHDOG_EN, .TWO_SPEED_EN, .SLOW_RC_IS_SYSCLK,
		.FAST_OSC_EN, .SLOW_RC_EN, .PLL_EN, .FAST_OSC_TRIM, .TRIM_SHIFTING, .BLOCK_CLK, .BLOCK_SRC,
		.PORT_A7_OUT, .PORT_A7_OE, .PORT_A6_OUT, .PORT_A6_OE, .OSC_PIN_IN_I, .OSC_PIN_OUT_I, .OSC_PIN_IN_O,
		.OSC_PIN_IN_OE, .OSC_PIN_OUT_O, .OSC_PIN_OUT_OE, .PORT_A7_IN, .PORT_A6_IN);
	// ----------------------------------------
	// Clock, oscillator ticks and hang guard
	// ----------------------------------------
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc <= cyc + 1;
		FAST_OSC_TICK <= cyc[0];
		SLOW_RC_TICK <= (cyc[3:0] == 4'h0);
		PLL_TICK <= ~cyc[0];
		if (cyc == 6000) begin
			err_total++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One single transfer; waits on ready, no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= a;
		HTRANS <= 2'h2;
		HWRITE <= wr;
		do @(posedge CLK); while (HREADY !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADY !== 1'b1);
		rd = HRDATA;
	endtask
	task automatic step();
		@(posedge CLK);
		#1;
	endtask
	// Counts level changes of the pin output or the block clock over 8 cycles
	task automatic count_toggles(input logic use_pin, output int t);
		logic prev;
		logic now;
		t = 0;
		prev = use_pin ? OSC_PIN_OUT_O : BLOCK_CLK;
		repeat (8) begin
			step();
			now = use_pin ? OSC_PIN_OUT_O : BLOCK_CLK;
			t += (now !== prev);
			prev = now;
		end
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{HSEL, HWRITE, FAST_OSC_TICK, SLOW_RC_TICK, PLL_TICK, PWRUP_TIMER_EN, FAILSAFE_MON_EN} = '0;
		{WATCHDOG_EN, TWO_SPEED_EN, SLOW_RC_IS_SYSCLK, PORT_A7_OUT, PORT_A7_OE, PORT_A6_OUT} = '0;
		{PORT_A6_OE, OSC_PIN_IN_I, OSC_PIN_OUT_I, HADDR, HTRANS, HWDATA} = '0;
		{err_total, checked, cyc} = '0;
		HSIZE = 3'h2;
		SYS_CLK_TICK = 1'b1;
		SRST = 1'b1;
		repeat (5) @(posedge CLK);
		SRST <= 1'b0;
		// Reset state: 1 MHz select, tuning clear, unmapped reads zero
		bus(0, `IOB_OFS_TUNING, 0); check(rd, 32'h00);
		bus(0, `IOB_OFS_CONTROL, 0); check(rd, 32'h40);
		bus(0, `IOB_OFS_STATUS, 0); check(rd, 32'h11);
		bus(0, 8'h20, 0); check(rd, 32'h0);
		$display("reset test done");
		// Full write: bit 5 and unavailable pll bit stay low
		bus(1, `IOB_OFS_TUNING, 32'hff);
		step(); check({27'h0, FAST_OSC_TRIM}, 32'h1f);
		check(TRIM_SHIFTING, 1);
		check(SLOW_RC_EN, 0);
		n = 0;
		while (TRIM_SHIFTING === 1'b1 && n < 60) begin
			step();
			n++;
		end
		check(n <= SETTLE + 2, 1);
		bus(0, `IOB_OFS_TUNING, 0); check(rd, 32'h9f);
		for (c = 0; c < 3; c++) begin
			bus(1, `IOB_OFS_TUNING, {27'h0, trims[c]});
			step(); check({27'h0, FAST_OSC_TRIM}, {27'h0, trims[c]});
		end
		// Software steering: read and lower the trim twice, then write the last read value plus one, back to zero
		bus(0, `IOB_OFS_TUNING, 0);
		bus(1, `IOB_OFS_TUNING, {27'h0, rd[4:0] - 5'h01});
		step();
		check(32'(FAST_OSC_TRIM), 32'hffff_ffff);
		bus(0, `IOB_OFS_TUNING, 0);
		bus(1, `IOB_OFS_TUNING, {27'h0, rd[4:0] - 5'h01});
		step();
		check(32'(FAST_OSC_TRIM), 32'hffff_fffe);
		bus(1, `IOB_OFS_TUNING, {27'h0, rd[4:0] + 5'h01});
		step();
		check(32'(FAST_OSC_TRIM), 32'h0);
		$display("tuning test done");
		// Pll availability over config and select
		for (c = 0; c < 3; c++) begin
			for (s = 0; s < 3; s++) begin
				bus(1, `IOB_OFS_CONFIG, {28'h0, cfgs[c]});
				bus(1, `IOB_OFS_CONTROL, {25'h0, sels[s], 4'h0});
				bus(1, `IOB_OFS_TUNING, 32'h40);
				step(); check(PLL_EN, c < 2 && s < 2);
				check(BLOCK_SRC, (c < 2 && s < 2) ? IOB_SRC_PLL : (s == 0 ? IOB_SRC_FAST : IOB_SRC_POST));
				bus(0, `IOB_OFS_TUNING, 0); check(rd, (c < 2 && s < 2) ? 32'h40 : 32'h0);
			end
		end
		bus(1, `IOB_OFS_CONFIG, 32'h9);
		bus(1, `IOB_OFS_CONTROL, 32'h70);
		bus(1, `IOB_OFS_TUNING, 32'h40);
		bus(1, `IOB_OFS_CONTROL, 32'h50);
		bus(1, `IOB_OFS_CONTROL, 32'h70);
		bus(0, `IOB_OFS_TUNING, 0); check(rd, 32'h0);
		$display("pll test done");
		// Low-frequency source choice at select zero
		bus(1, `IOB_OFS_CONTROL, 32'h00);
		bus(1, `IOB_OFS_TUNING, 32'h80);
		step(); check({FAST_OSC_EN, BLOCK_SRC}, {1'b1, IOB_SRC_DIV256});
		bus(1, `IOB_OFS_TUNING, 32'h00);
		step(); check({FAST_OSC_EN, BLOCK_SRC}, {1'b0, IOB_SRC_SLOW_RC});
		for (c = 0; c < 6; c++) begin
			@(posedge CLK);
			{PWRUP_TIMER_EN, FAILSAFE_MON_EN, WATCHDOG_EN, TWO_SPEED_EN, SLOW_RC_IS_SYSCLK} <= 5'(6'h1 << c);
			step(); check(SLOW_RC_EN, c < 5);
		end
		// Block clock: direct fast source runs twice the 4 MHz postscaler tap
		bus(1, `IOB_OFS_CONTROL, 32'h70);
		step();
		count_toggles(1'b0, n);
		check(n, 8);
		bus(1, `IOB_OFS_CONTROL, 32'h60);
		step();
		count_toggles(1'b0, n);
		check(n, 4);
		$display("source test done");
		// Pin reuse in the two internal modes
		@(posedge CLK);
		{PORT_A7_OUT, PORT_A7_OE, PORT_A6_OUT, PORT_A6_OE, OSC_PIN_IN_I, OSC_PIN_OUT_I} <= 6'h26;
		bus(1, `IOB_OFS_CONFIG, 32'h8);
		step(); check({OSC_PIN_OUT_O, OSC_PIN_OUT_OE, PORT_A6_IN, OSC_PIN_IN_O, OSC_PIN_IN_OE, PORT_A7_IN}, 6'h15);
		bus(1, `IOB_OFS_CONFIG, 32'h9);
		step(); check({OSC_PIN_IN_O, PORT_A7_IN, OSC_PIN_OUT_OE, PORT_A6_IN}, 4'he);
		count_toggles(1'b1, n);
		check(n, 4);
		$display("pin test done");
		report_and_stop();
	end
endmodule
bind iob_core iob_core_chk #(.SETTLE_CYC(SETTLE_CYC)) iob_core_chk_inst (.CLK, .SRST, .HSEL, .HADDR, .HTRANS,
	.HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .FAST_OSC_EN, .PLL_EN, .FAST_OSC_TRIM, .TRIM_SHIFTING,
	.BLOCK_SRC);
`default_nettype wire
